// ==== hw/gfr_byte_reg.sv ====
// One read-only result byte register with its own reset value
`timescale 1ns/100ps
`default_nettype none
module gfr_byte_reg #(
  parameter logic [gfr_pkg::DATA_W-1:0] RESET_VALUE = 8'h00
) (
  input wire logic ref_clk,
  input wire logic rst,
  gfr_load_if.dst port
);
  import gfr_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] value;
  } gfr_byte_state_t;

  gfr_byte_state_t state;
  gfr_byte_state_t next_state;

  // Take a new result only from the producing logic
  always_comb begin
    next_state = state;
    if (port.load) begin
      next_state.value = port.value;
    end
  end

  // Register the state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= '{value: RESET_VALUE};
    end else begin
      state <= next_state;
    end
  end

  assign port.held = state.value;
endmodule : gfr_byte_reg
`default_nettype wire

// ==== hw/gfr_load_if.sv ====
// Interface carrying one result byte and its load strobe into a holding register
`timescale 1ns/100ps
`default_nettype none
interface gfr_load_if;
  import gfr_pkg::*;
  logic load;
  logic [DATA_W-1:0] value;
  logic [DATA_W-1:0] held;
  modport src (output load, output value, input held);
  modport dst (input load, input value, output held);
endinterface : gfr_load_if
`default_nettype wire

// ==== hw/gfr_pkg.sv ====
// Package of offsets, reset values and access types for the gyro and freefall result slice
package gfr_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned REG_COUNT = 7;
  localparam int unsigned IDX_W = 3;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RATE_Y_LOW = 7'h14;
  localparam logic [ADDR_W-1:0] ADDR_RATE_Z_HIGH = 7'h15;
  localparam logic [ADDR_W-1:0] ADDR_RATE_Z_LOW = 7'h16;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_STAMP_HIGH = 7'h17;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_STAMP_LOW = 7'h18;
  localparam logic [ADDR_W-1:0] ADDR_FALL_LENGTH_LOW = 7'h1d;
  localparam logic [ADDR_W-1:0] ADDR_FALL_LENGTH_HIGH = 7'h1e;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [DATA_W-1:0] RST_RATE_Y_LOW = 8'h00;
  localparam logic [DATA_W-1:0] RST_RATE_Z_HIGH = 8'h80;
  localparam logic [DATA_W-1:0] RST_RATE_Z_LOW = 8'h00;
  localparam logic [DATA_W-1:0] RST_SYNC_STAMP_HIGH = 8'h00;
  localparam logic [DATA_W-1:0] RST_SYNC_STAMP_LOW = 8'h00;
  localparam logic [DATA_W-1:0] RST_FALL_LENGTH_LOW = 8'h00;
  localparam logic [DATA_W-1:0] RST_FALL_LENGTH_HIGH = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------
  // Register slot indices
  // ----------------------------------------
  localparam logic [IDX_W-1:0] IDX_RATE_Y_LOW = 3'h0;
  localparam logic [IDX_W-1:0] IDX_RATE_Z_HIGH = 3'h1;
  localparam logic [IDX_W-1:0] IDX_RATE_Z_LOW = 3'h2;
  localparam logic [IDX_W-1:0] IDX_SYNC_STAMP_HIGH = 3'h3;
  localparam logic [IDX_W-1:0] IDX_SYNC_STAMP_LOW = 3'h4;
  localparam logic [IDX_W-1:0] IDX_FALL_LENGTH_LOW = 3'h5;
  localparam logic [IDX_W-1:0] IDX_FALL_LENGTH_HIGH = 3'h6;

  // Serial access type of a register
  typedef enum logic [0:0] {
    GFR_ACC_READ = 1'b0,
    GFR_ACC_SYNCHRONISED_READ_ACCESS = 1'b1
  } gfr_access_t;
endpackage : gfr_pkg

// ==== hw/gfr_result_regs.sv ====
// Gyro Y/Z, frame-sync stamp and freefall length result registers with host read port
// How it works
// - Y rate low byte readable at 14h, resets 0x00.
// - Z rate high byte readable at 15h, resets 0x80.
// - Z rate low byte readable at 16h, resets 0x00.
// - Stamp high 17h, low 18h, reset 0x00, synchronised read access only.
// - Fall length bits 7..0 readable at 1Dh, resets 0x00.
// - Fall length bits 15..8 readable at 1Eh, resets 0x00.
// - Fall length counts engine output samples; host scales by sample period.
`timescale 1ns/100ps
`default_nettype none
module gfr_result_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] rate_y_in,
  input wire logic [15:0] rate_z_in,
  input wire logic rate_valid,
  input wire logic [15:0] sync_stamp_in,
  input wire logic sync_stamp_valid,
  input wire logic [15:0] fall_length_count,
  input wire logic fall_length_valid,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [gfr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [gfr_pkg::DATA_W-1:0] reg_wdata,
  input wire gfr_pkg::gfr_access_t reg_access,
  output logic [gfr_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit
);
  import gfr_pkg::*;

  // ----------------------------------------
  // Holding registers
  // ----------------------------------------
  gfr_load_if slot [REG_COUNT] ();
  logic [DATA_W-1:0] held [REG_COUNT];

  // Load strobes come only from producers, never from the host bus
  assign slot[IDX_RATE_Y_LOW].load = rate_valid;
  assign slot[IDX_RATE_Y_LOW].value = rate_y_in[7:0];
  assign slot[IDX_RATE_Z_HIGH].load = rate_valid;
  assign slot[IDX_RATE_Z_HIGH].value = rate_z_in[15:8];
  assign slot[IDX_RATE_Z_LOW].load = rate_valid;
  assign slot[IDX_RATE_Z_LOW].value = rate_z_in[7:0];
  assign slot[IDX_SYNC_STAMP_HIGH].load = sync_stamp_valid;
  assign slot[IDX_SYNC_STAMP_HIGH].value = sync_stamp_in[15:8];
  assign slot[IDX_SYNC_STAMP_LOW].load = sync_stamp_valid;
  assign slot[IDX_SYNC_STAMP_LOW].value = sync_stamp_in[7:0];
  // Sample count stored raw, no scaling to time
  assign slot[IDX_FALL_LENGTH_LOW].load = fall_length_valid;
  assign slot[IDX_FALL_LENGTH_LOW].value = fall_length_count[7:0];
  assign slot[IDX_FALL_LENGTH_HIGH].load = fall_length_valid;
  assign slot[IDX_FALL_LENGTH_HIGH].value = fall_length_count[15:8];

  gfr_byte_reg #(.RESET_VALUE(RST_RATE_Y_LOW)) u_rate_y_low (
    .ref_clk(ref_clk), .rst(rst), .port(slot[IDX_RATE_Y_LOW])
  );
  gfr_byte_reg #(.RESET_VALUE(RST_RATE_Z_HIGH)) u_rate_z_high (
    .ref_clk(ref_clk), .rst(rst), .port(slot[IDX_RATE_Z_HIGH])
  );
  gfr_byte_reg #(.RESET_VALUE(RST_RATE_Z_LOW)) u_rate_z_low (
    .ref_clk(ref_clk), .rst(rst), .port(slot[IDX_RATE_Z_LOW])
  );
  gfr_byte_reg #(.RESET_VALUE(RST_SYNC_STAMP_HIGH)) u_sync_stamp_high (
    .ref_clk(ref_clk), .rst(rst), .port(slot[IDX_SYNC_STAMP_HIGH])
  );
  gfr_byte_reg #(.RESET_VALUE(RST_SYNC_STAMP_LOW)) u_sync_stamp_low (
    .ref_clk(ref_clk), .rst(rst), .port(slot[IDX_SYNC_STAMP_LOW])
  );
  gfr_byte_reg #(.RESET_VALUE(RST_FALL_LENGTH_LOW)) u_fall_length_low (
    .ref_clk(ref_clk), .rst(rst), .port(slot[IDX_FALL_LENGTH_LOW])
  );
  gfr_byte_reg #(.RESET_VALUE(RST_FALL_LENGTH_HIGH)) u_fall_length_high (
    .ref_clk(ref_clk), .rst(rst), .port(slot[IDX_FALL_LENGTH_HIGH])
  );

  // Gather held bytes for the read mux
  for (genvar i = 0; i < REG_COUNT; i++) begin : g_held
    assign held[i] = slot[i].held;
  end

  // ----------------------------------------
  // Host read port
  // ----------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic hit;
  } gfr_port_state_t;

  gfr_port_state_t state;
  gfr_port_state_t next_state;
  logic unused_write;

  // Writes have no path into the holding registers
  assign unused_write = reg_wr ^ (^reg_wdata);

  // Decode address and access type, answer one cycle after the read
  always_comb begin
    next_state = state;
    next_state.rvalid = reg_rd;
    next_state.hit = 1'b0;
    next_state.rdata = UNMAPPED_READ;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_RATE_Y_LOW: begin
          next_state.hit = (reg_access == GFR_ACC_READ);
          next_state.rdata = next_state.hit ? held[IDX_RATE_Y_LOW] : UNMAPPED_READ;
        end
        ADDR_RATE_Z_HIGH: begin
          next_state.hit = (reg_access == GFR_ACC_READ);
          next_state.rdata = next_state.hit ? held[IDX_RATE_Z_HIGH] : UNMAPPED_READ;
        end
        ADDR_RATE_Z_LOW: begin
          next_state.hit = (reg_access == GFR_ACC_READ);
          next_state.rdata = next_state.hit ? held[IDX_RATE_Z_LOW] : UNMAPPED_READ;
        end
        ADDR_SYNC_STAMP_HIGH: begin
          next_state.hit = (reg_access == GFR_ACC_SYNCHRONISED_READ_ACCESS);
          next_state.rdata = next_state.hit ? held[IDX_SYNC_STAMP_HIGH] : UNMAPPED_READ;
        end
        ADDR_SYNC_STAMP_LOW: begin
          next_state.hit = (reg_access == GFR_ACC_SYNCHRONISED_READ_ACCESS);
          next_state.rdata = next_state.hit ? held[IDX_SYNC_STAMP_LOW] : UNMAPPED_READ;
        end
        ADDR_FALL_LENGTH_LOW: begin
          next_state.hit = (reg_access == GFR_ACC_READ);
          next_state.rdata = next_state.hit ? held[IDX_FALL_LENGTH_LOW] : UNMAPPED_READ;
        end
        ADDR_FALL_LENGTH_HIGH: begin
          next_state.hit = (reg_access == GFR_ACC_READ);
          next_state.rdata = next_state.hit ? held[IDX_FALL_LENGTH_HIGH] : UNMAPPED_READ;
        end
        default: begin
          next_state.hit = 1'b0;
          next_state.rdata = UNMAPPED_READ;
        end
      endcase
    end
  end

  // Register the read port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= '{rdata: UNMAPPED_READ, rvalid: 1'b0, hit: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign reg_rvalid = state.rvalid;
  assign reg_hit = state.hit;
endmodule : gfr_result_regs
`default_nettype wire

// ==== testbench/gfr_host.sv ====
// Host model driving the result slice read port
`timescale 1ns/100ps
`default_nettype none
module gfr_host (
  input wire logic ref_clk,
  output var logic reg_rd,
  output var logic reg_wr,
  output var logic [gfr_pkg::ADDR_W-1:0] reg_addr,
  output var logic [gfr_pkg::DATA_W-1:0] reg_wdata,
  output var gfr_pkg::gfr_access_t reg_access
);
  import gfr_pkg::*;
  // Quiet bus at time zero
  initial begin
    {reg_rd, reg_wr, reg_addr, reg_wdata} = '0;
    reg_access = GFR_ACC_READ;
  end
  // One request, held until the taking edge
  task automatic xfer(input logic rd, input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input gfr_access_t acc);
    {reg_rd, reg_wr, reg_addr, reg_wdata} = {rd, wr, a, d};
    reg_access = acc;
    @(posedge ref_clk);
    #1;
  endtask : xfer
  // Release: unused lines toggle so stale values never look valid
  task automatic idle();
    {reg_rd, reg_wr} = 2'b00;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask : idle
endmodule : gfr_host
`default_nettype wire

// ==== testbench/gfr_props.sv ====
// Checker of the result slice read port
`timescale 1ns/100ps
`default_nettype none
module gfr_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] rate_z_in,
  input wire logic [15:0] fall_length_count,
  input wire logic rate_valid,
  input wire logic fall_length_valid,
  input wire logic reg_rd,
  input wire logic [gfr_pkg::ADDR_W-1:0] reg_addr,
  input wire gfr_pkg::gfr_access_t reg_access,
  input wire logic [gfr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit
);
  import gfr_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Ordinary read of one address
  function automatic logic rd_at(input logic [ADDR_W-1:0] a);
    return reg_rd && reg_access == GFR_ACC_READ && reg_addr == a;
  endfunction : rd_at
  // Read answer timing and idle levels
  rvalid_timing_a: assert property (reg_rvalid == $past(reg_rd)) else $error("rvalid timing");
  idle_zero_a: assert property (!reg_rvalid |-> reg_rdata == 8'h00 && !reg_hit) else $error("idle out");
  refused_zero_a: assert property (reg_rvalid && !reg_hit |-> reg_rdata == 8'h00) else $error("refused");
  stamp_plain_a: assert property (reg_rd && reg_access == GFR_ACC_READ && reg_addr inside {7'h17, 7'h18}
    |=> !reg_hit) else $error("stamp hit");
  // Freshly loaded bytes read back
  z_high_a: assert property (rate_valid ##1 rd_at(7'h15) |=> reg_rdata == $past(rate_z_in[15:8], 2))
    else $error("z high");
  z_low_a: assert property (rate_valid ##1 rd_at(7'h16) |=> reg_rdata == $past(rate_z_in[7:0], 2))
    else $error("z low");
  fall_low_a: assert property (fall_length_valid ##1 rd_at(7'h1d)
    |=> reg_rdata == $past(fall_length_count[7:0], 2)) else $error("fall low");
  fall_high_a: assert property (fall_length_valid ##1 rd_at(7'h1e)
    |=> reg_rdata == $past(fall_length_count[15:8], 2)) else $error("fall high");
  cover property (reg_rvalid && reg_hit);
  cover property (reg_rvalid && !reg_hit);
  cover property (rate_valid ##1 reg_rd);
endmodule : gfr_props
bind gfr_result_regs gfr_props chk (.ref_clk(ref_clk), .rst(rst), .rate_z_in(rate_z_in),
  .fall_length_count(fall_length_count), .rate_valid(rate_valid), .fall_length_valid(fall_length_valid),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_access(reg_access), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .reg_hit(reg_hit));
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench of the result slice
`timescale 1ns/100ps
`default_nettype none
module tb;
  import gfr_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] rate_y_in = '0, rate_z_in = '0, sync_stamp_in = '0, fall_length_count = '0;
  logic rate_valid = 1'b0, sync_stamp_valid = 1'b0, fall_length_valid = 1'b0;
  logic reg_rd, reg_wr, reg_rvalid, reg_hit;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  gfr_access_t reg_access;
  logic [DATA_W:0] exp_q [$];
  logic [DATA_W-1:0] shadow [REG_COUNT];
  logic [ADDR_W-1:0] addrs [REG_COUNT];
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  // Clock
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  gfr_host host (.ref_clk(ref_clk), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_access(reg_access));
  gfr_result_regs dut (.ref_clk(ref_clk), .rst(rst), .rate_y_in(rate_y_in), .rate_z_in(rate_z_in),
    .rate_valid(rate_valid), .sync_stamp_in(sync_stamp_in), .sync_stamp_valid(sync_stamp_valid),
    .fall_length_count(fall_length_count), .fall_length_valid(fall_length_valid), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_access(reg_access),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit));
  // Verdict and end of run
  task automatic give_verdict();
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("[ERR] %0t answers missing", $time);
    end
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // Compare hit flag and data of one answer
  task automatic cmp_read(input logic [DATA_W:0] e);
    num_checks++;
    if ({reg_hit, reg_rdata} !== e) begin
      bad_count++;
      $display("[ERR] %0t read got %h want %h", $time, {reg_hit, reg_rdata}, e);
    end
  endtask : cmp_read
  // Back-to-back reads of all slots from a rotating start, right or wrong access type
  task automatic read_all(input int r, input logic good);
    int i;
    for (int k = 0; k < REG_COUNT; k++) begin
      i = (r + k) % REG_COUNT;
      exp_q.push_back(good ? {1'b1, shadow[i]} : 9'h000);
      host.xfer(1'b1, 1'b0, addrs[i], ~reg_wdata, gfr_access_t'((i == 3 || i == 4) ~^ good));
    end
    host.idle();
  endtask : read_all
  // Load random results into all three groups at one edge
  task automatic load_all();
    {rate_y_in, rate_z_in, sync_stamp_in, fall_length_count} = {$urandom, $urandom};
    {rate_valid, sync_stamp_valid, fall_length_valid} = 3'b111;
    shadow = '{rate_y_in[7:0], rate_z_in[15:8], rate_z_in[7:0], sync_stamp_in[15:8], sync_stamp_in[7:0],
      fall_length_count[7:0], fall_length_count[15:8]};
    @(posedge ref_clk);
    #1;
    {rate_valid, sync_stamp_valid, fall_length_valid} = 3'b000;
  endtask : load_all
  // Main sequence
  initial begin
    void'($urandom(27648));
    addrs = '{ADDR_RATE_Y_LOW, ADDR_RATE_Z_HIGH, ADDR_RATE_Z_LOW, ADDR_SYNC_STAMP_HIGH, ADDR_SYNC_STAMP_LOW,
      ADDR_FALL_LENGTH_LOW, ADDR_FALL_LENGTH_HIGH};
    shadow = '{RST_RATE_Y_LOW, RST_RATE_Z_HIGH, RST_RATE_Z_LOW, RST_SYNC_STAMP_HIGH, RST_SYNC_STAMP_LOW,
      RST_FALL_LENGTH_LOW, RST_FALL_LENGTH_HIGH};
    repeat (12) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    read_all(0, 1'b1);
    read_all(0, 1'b0);
    exp_q.push_back(9'h000);
    host.xfer(1'b1, 1'b0, 7'h19, 8'h00, GFR_ACC_READ);
    host.idle();
    for (int r = 0; r < REG_COUNT; r++) begin
      load_all();
      read_all(r, 1'b1);
      for (int i = 0; i < REG_COUNT; i++) host.xfer(1'b0, 1'b1, addrs[i], 8'($urandom), GFR_ACC_READ);
      host.idle();
      read_all(r, 1'b1);
    end
    repeat (3) @(posedge ref_clk);
    give_verdict();
  end
  // Watch answers and bound the run
  always @(posedge ref_clk) begin
    #2;
    cycles++;
    if (cycles > 1000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
    if (reg_rvalid === 1'b1) cmp_read(exp_q.size() ? exp_q.pop_front() : 9'h1xx);
  end
endmodule : tb
`default_nettype wire
